// ### verilog/mdt_pkg.sv
// Package of constants for the channel mux and sinc5 decimator
package mdt_pkg;
    localparam int MOD_DIV = 6;
    localparam int OSR = 64;
    localparam int SINC_ORDER = 5;
    localparam int SETTLE_CONV = 5;
    localparam int SETTLE_MOD = SETTLE_CONV * OSR;
    localparam int SETTLE_CLKS = SETTLE_MOD * MOD_DIV;
    localparam int RESULT_W = 24;
    localparam int ACC_W = 31;
    localparam int FIFO_DEPTH = 16;
    localparam int CHAN_W = 2;
    localparam logic [1:0] SEL_PAIR_1 = 2'h0;
    localparam logic [1:0] SEL_PAIR_2 = 2'h1;
    localparam logic [1:0] SEL_PAIR_3 = 2'h2;
    localparam logic [1:0] SEL_PAIR_4 = 2'h3;
    localparam logic [3:0] ONEHOT_RESET = 4'h1;
    localparam int SYS_CLK_KHZ = 100000;
    localparam int RATE_SETTLE = 0;
    typedef enum logic [1:0] {
        MDT_SETTLE = 2'b00,
        MDT_RUN = 2'b01
    } mdt_state_t;
endpackage

// ### verilog/mdt_fifo.sv
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ns
module mdt_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk, // clock
    input wire logic resetn, // async reset, active low
    input wire logic flush, // drop all contents
    input wire logic in_valid, // write request
    output logic in_ready, // room available
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // data available
    input wire logic out_ready, // read accept
    output logic [WIDTH-1:0] out_data // read data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic do_wr;
    logic do_rd;

    assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    assign out_data = mem[rd_reg[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (flush) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (do_wr) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule

// ### verilog/mdt_core.sv
// Channel mux control, modulator clock divider and sinc5 decimator
//
// Overview of operation
// R1: Select code 00,01,10,11 picks input pair 1,2,3,4.
// R2: Selects are sampled on each falling clock edge and a change restarts conversion.
// R3: After a channel change ready is given only after five conversion cycles.
// R4: The host reads the pending result before changing channel.
// R5: The modulator enable comes from a fixed divide-by-six of the system clock.
// R6: One output word is produced per 64 modulator results.
// R7: The word rate is the system clock over 384, so it scales with the clock.
// R8: The filter is a fifth-order sinc decimator (integrators then combs).
// R9: Notches fall at the word rate and its multiples, from the 64-tap boxcar.
// R10: The half-power bandwidth, 0.2035 of word rate, follows from sinc5 shape.
// R11: Settling takes five conversions, 320 modulator results, 1920 clocks.
// R12: A step between ready pulses settles on the sixth conversion after it.
// R13: The clock source picks the notch frequency; nothing to do here.
// R14: Results are 24-bit offset two's complement, shifted out MSB first.
// R15: Writing a new result to the output register drives the pin low.
// R16: A restart clears integrators, combs and the conversion counter.
// R17: Ready pulses are withheld while unsettled, then one per conversion; the code also withholds them while the FIFO is full.
`timescale 1ns/1ns
module mdt_core
    import mdt_pkg::*;
#(
    parameter int OSR_P = mdt_pkg::OSR,
    parameter int SETTLE_P = mdt_pkg::SETTLE_CONV
) (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic chan_pick_hi, // channel select bit 1
    input wire logic chan_pick_lo, // channel select bit 0
    input wire logic mod_bit, // modulator bitstream from front end
    input wire logic shift_clk, // serial shift strobe, one cycle pulse
    output logic [3:0] input_pair_sel, // one-hot pair enable 1..4
    output logic mod_clk_en, // modulator sample strobe
    output logic result_ready_pulse, // one-cycle new result strobe
    output logic [mdt_pkg::RESULT_W-1:0] result_word, // last result
    output logic serial_out_ready_pin, // combined data/ready line
    output logic settled // filter settled on current channel
);
    import mdt_pkg::*;

    logic [CHAN_W-1:0] sel_fall_reg;
    logic [CHAN_W-1:0] sel_prev_reg;
    logic restart;
    logic [2:0] div_reg;
    logic tick;
    logic [ACC_W-1:0] integ_reg [SINC_ORDER];
    logic [ACC_W-1:0] comb_reg [SINC_ORDER];
    logic [ACC_W-1:0] comb_next [SINC_ORDER];
    logic [5:0] dec_reg;
    logic [3:0] conv_reg;
    logic word_strobe;
    logic [RESULT_W-1:0] word_value;
    logic fifo_out_valid;
    logic fifo_in_ready;
    logic [RESULT_W-1:0] fifo_out_data;
    logic pop;
    logic [RESULT_W-1:0] shift_reg;
    logic [4:0] bit_cnt_reg;
    logic idle_reg;
    mdt_state_t state_reg;

    // R2: selects sampled on the falling edge, compared in next rising cycle
    always_ff @(negedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sel_fall_reg <= SEL_PAIR_1;
        end else begin
            sel_fall_reg <= {chan_pick_hi, chan_pick_lo};
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sel_prev_reg <= SEL_PAIR_1;
        end else begin
            sel_prev_reg <= sel_fall_reg;
        end
    end
    assign restart = sel_prev_reg != sel_fall_reg;

    // R1: binary decode of the select code
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            input_pair_sel <= ONEHOT_RESET;
        end else begin
            case (sel_fall_reg)
                SEL_PAIR_1: input_pair_sel <= 4'h1;
                SEL_PAIR_2: input_pair_sel <= 4'h2;
                SEL_PAIR_3: input_pair_sel <= 4'h4;
                SEL_PAIR_4: input_pair_sel <= 4'h8;
                default: input_pair_sel <= ONEHOT_RESET;
            endcase
        end
    end

    // R5: fixed divide by six; restart realigns the phase
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= '0;
        end else if (restart || div_reg == 3'(MOD_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end
    assign tick = div_reg == 3'(MOD_DIV - 1) && !restart;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mod_clk_en <= 1'b0;
        end else begin
            mod_clk_en <= tick;
        end
    end

    // R8: five cascaded integrators at the modulator rate
    // R16: cleared on restart
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < SINC_ORDER; i++) begin
                integ_reg[i] <= '0;
            end
        end else if (restart) begin
            for (int i = 0; i < SINC_ORDER; i++) begin
                integ_reg[i] <= '0;
            end
        end else if (tick) begin
            integ_reg[0] <= integ_reg[0] + ACC_W'(mod_bit);
            for (int i = 1; i < SINC_ORDER; i++) begin
                integ_reg[i] <= integ_reg[i] + integ_reg[i-1];
            end
        end
    end

    // R6: decimation by 64
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dec_reg <= '0;
        end else if (restart) begin
            dec_reg <= '0;
        end else if (tick) begin
            dec_reg <= dec_reg + 6'h1;
        end
    end
    // R7: one word per 384 system clocks
    assign word_strobe = tick && dec_reg == 6'(OSR_P - 1);

    // R9: differentiators at output rate; wraparound is intended
    always_comb begin
        comb_next[0] = integ_reg[SINC_ORDER-1] - comb_reg[0];
        for (int i = 1; i < SINC_ORDER; i++) begin
            comb_next[i] = comb_next[i-1] - comb_reg[i];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < SINC_ORDER; i++) begin
                comb_reg[i] <= '0;
            end
        end else if (restart) begin
            for (int i = 0; i < SINC_ORDER; i++) begin
                comb_reg[i] <= '0;
            end
        end else if (word_strobe) begin
            comb_reg[0] <= integ_reg[SINC_ORDER-1];
            for (int i = 1; i < SINC_ORDER; i++) begin
                comb_reg[i] <= comb_next[i-1];
            end
        end
    end

    // R14: gain 2^30 scaled to 24 bits, midscale to zero (offset two's comp)
    // R10: the bandwidth is a property of this gain-normalised sinc5
    assign word_value = {~comb_next[SINC_ORDER-1][ACC_W-2],
                         comb_next[SINC_ORDER-1][ACC_W-3 -: RESULT_W-1]};

    // R11: count conversions since restart
    // R12: an unaligned step lands inside a frame, so one more is needed
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            conv_reg <= '0;
            state_reg <= MDT_SETTLE;
        end else if (restart) begin
            conv_reg <= '0;
            state_reg <= MDT_SETTLE;
        end else if (word_strobe) begin
            case (state_reg)
                MDT_SETTLE: begin
                    conv_reg <= conv_reg + 4'h1;
                    if (conv_reg == 4'(SETTLE_P - 1)) begin
                        state_reg <= MDT_RUN;
                    end
                end
                MDT_RUN: state_reg <= MDT_RUN;
                default: state_reg <= MDT_SETTLE;
            endcase
        end
    end

    // R3: first pulse only on the fifth conversion after a change
    // R17: unsettled words are dropped, later one per conversion while the FIFO has room
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            result_ready_pulse <= 1'b0;
            result_word <= '0;
            settled <= 1'b0;
        end else begin
            result_ready_pulse <= 1'b0;
            // Rises with the first ready pulse, not one cycle behind it
            settled <= !restart && (state_reg == MDT_RUN ||
                (word_strobe && conv_reg == 4'(SETTLE_P - 1)));
            if (word_strobe && !restart && fifo_in_ready &&
                (state_reg == MDT_RUN ||
                 conv_reg == 4'(SETTLE_P - 1))) begin
                result_ready_pulse <= 1'b1;
                result_word <= word_value;
            end
        end
    end

    // Buffer absorbs results the host has not yet drained
    mdt_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .flush(restart),
        .in_valid(result_ready_pulse),
        .in_ready(fifo_in_ready),
        .in_data(result_word),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // R15: pin goes low when a word is loaded; then MSB first on shifts
    // R4: a restart flushes any half-read word
    assign pop = fifo_out_valid && bit_cnt_reg == '0 && idle_reg;

    // Pin must sit high a full cycle between words or the host misses
    // the next low announce when the FIFO drains back to back
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            idle_reg <= 1'b0;
        end else begin
            idle_reg <= bit_cnt_reg == '0 && serial_out_ready_pin && !pop;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shift_reg <= '0;
            bit_cnt_reg <= '0;
            serial_out_ready_pin <= 1'b1;
        end else if (restart) begin
            bit_cnt_reg <= '0;
            serial_out_ready_pin <= 1'b1;
        end else if (pop) begin
            shift_reg <= fifo_out_data;
            bit_cnt_reg <= 5'(RESULT_W);
            serial_out_ready_pin <= 1'b0;
        end else if (shift_clk && bit_cnt_reg != '0) begin
            serial_out_ready_pin <= shift_reg[RESULT_W-1];
            shift_reg <= {shift_reg[RESULT_W-2:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg - 5'h1;
        end else if (bit_cnt_reg == '0) begin
            serial_out_ready_pin <= 1'b1;
        end
    end
endmodule

// ### testbench/mdt_core_checker.sv
// Assertions on select decode, divider and result pacing
`timescale 1ns/1ns
module mdt_core_checker #(
    parameter int OSR_P = 64,
    parameter int SETTLE_P = 5
) (
    input wire logic sys_clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic chan_pick_hi, // select bit 1
    input wire logic chan_pick_lo, // select bit 0
    input wire logic [3:0] input_pair_sel, // pair enable
    input wire logic mod_clk_en, // modulator strobe
    input wire logic result_ready_pulse, // new result
    input wire logic serial_out_ready_pin, // data/ready line
    input wire logic settled // settled level
);
    localparam int CONV = OSR_P * 6;
    logic [1:0] sel;
    logic [11:0] since_reg;
    logic [9:0] gap_reg;
    logic had_reg;
    assign sel = {chan_pick_hi, chan_pick_lo};
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            since_reg <= 12'h0;
        end else if ($changed(sel)) begin
            since_reg <= 12'h0;
        end else if (since_reg != 12'hfff) begin
            since_reg <= since_reg + 12'h1;
        end
    end
    // Spacing only counts between pulses of one channel
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= 10'h0;
            had_reg <= 1'b0;
        end else if (result_ready_pulse) begin
            gap_reg <= 10'h0;
            had_reg <= !$changed(sel);
        end else begin
            gap_reg <= gap_reg + 10'h1;
            // A word dropped on a full FIFO breaks the spacing chain
            had_reg <= had_reg && !$changed(sel) && gap_reg < CONV - 1;
        end
    end
    a_pair_decode: assert property ($stable(sel) [*3] |->
        input_pair_sel == (4'h1 << sel)) else $error("pair enable wrong");
    a_mod_div: assert property (mod_clk_en |=> (!mod_clk_en) [*5])
        else $error("modulator strobe closer than 6");
    a_mod_period: assert property (mod_clk_en && $stable(sel) ##1
        $stable(sel) [*5] |=> mod_clk_en)
        else $error("modulator strobe not every 6");
    a_pulse_one: assert property (result_ready_pulse |=>
        !result_ready_pulse) else $error("ready longer than one cycle");
    a_pulse_settled: assert property (result_ready_pulse |-> settled)
        else $error("ready while unsettled");
    a_change_unsettle: assert property ($changed(sel) |-> ##[0:3]
        !settled) else $error("select change kept settled");
    a_settle_min: assert property (result_ready_pulse |->
        since_reg >= SETTLE_P * CONV - 1) else $error("ready too soon");
    a_settle_max: assert property (since_reg == SETTLE_P * CONV + 20
        |-> settled) else $error("not settled in time");
    a_word_rate: assert property (result_ready_pulse && had_reg |->
        gap_reg == CONV - 1) else $error("result spacing wrong");
    c_restart: cover property ($changed(sel));
    c_spaced: cover property (result_ready_pulse && had_reg);
    c_pin_low: cover property ($fell(serial_out_ready_pin));
endmodule
bind mdt_core mdt_core_checker #(.OSR_P(OSR_P), .SETTLE_P(SETTLE_P))
    mdt_core_checker_i (.sys_clk, .resetn, .chan_pick_hi, .chan_pick_lo,
    .input_pair_sel, .mod_clk_en, .result_ready_pulse,
    .serial_out_ready_pin, .settled);

// ### testbench/mdt_host_model.sv
// Host model that reads result words off the data/ready line
`timescale 1ns/1ns
module mdt_host_model (
    input wire logic sys_clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic serial_out_ready_pin, // data/ready line
    input wire logic stall, // slow host: hold off shifting
    output logic shift_clk, // one-cycle shift strobe
    output logic [23:0] word, // last word read
    output logic done // one-cycle word complete
);
    logic busy, arm;
    logic [1:0] ph;
    logic [4:0] n;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            arm <= 1'b0;
            ph <= 2'h0;
            n <= 5'h0;
            shift_clk <= 1'b0;
            word <= 24'h0;
            done <= 1'b0;
        end else begin
            shift_clk <= 1'b0;
            done <= 1'b0;
            if (!busy) begin
                arm <= arm | serial_out_ready_pin;
                busy <= arm && !serial_out_ready_pin;
                ph <= 2'h0;
                n <= 5'h0;
            end else if (!stall) begin
                // Bit is sampled two edges after the strobe, never racing it
                if (ph == 2'h0) begin
                    shift_clk <= 1'b1;
                    ph <= 2'h1;
                end else if (ph == 2'h1) begin
                    ph <= 2'h2;
                end else begin
                    ph <= 2'h0;
                    word <= {word[22:0], serial_out_ready_pin};
                    n <= n + 5'h1;
                    busy <= n != 5'd23;
                    done <= n == 5'd23;
                    arm <= 1'b0;
                end
            end
        end
    end
endmodule

// ### testbench/mdt_core_tb.sv
// Self-checking bench for the channel mux and decimator block
`timescale 1ns/1ns
module mdt_core_tb;
    import mdt_pkg::*;
    logic sys_clk, resetn, hi, lo, mod_bit, stall, shift_clk;
    logic mod_en, pulse, pulse_d, pin, settled, done, cmp_on;
    logic [1:0] pat;
    logic [7:0] mcnt;
    logic [3:0] pair;
    logic [RESULT_W-1:0] rword, word, expq[$];
    int err_total, checks;
    mdt_core mdt_core_i (.sys_clk(sys_clk), .resetn(resetn),
        .chan_pick_hi(hi), .chan_pick_lo(lo), .mod_bit(mod_bit),
        .shift_clk(shift_clk), .input_pair_sel(pair), .mod_clk_en(mod_en),
        .result_ready_pulse(pulse), .result_word(rword),
        .serial_out_ready_pin(pin), .settled(settled));
    mdt_host_model mdt_host_model_i (.sys_clk(sys_clk), .resetn(resetn),
        .serial_out_ready_pin(pin), .stall(stall), .shift_clk(shift_clk),
        .word(word), .done(done));
    // fixed clock source, notches follow the word rate
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Densities 0, 1/4, 1/2 and a square wave of period 64 samples
    always @(posedge sys_clk) begin
        pulse_d <= pulse;
        if (mod_en) begin
            mcnt <= mcnt + 8'h1;
            mod_bit <= ((pat == 2'h1) & (mcnt[1:0] == 2'h0))
                | ((pat == 2'h2) & mcnt[0]) | ((pat == 2'h3) & mcnt[5]);
        end
        if (pulse_d && cmp_on) expq.push_back(rword);
        if (done && cmp_on && expq.size() > 0)
            cmp("serial", expq.pop_front(), word);
    end
    task automatic cmp(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk(input string nm, input logic ok);
        cmp(nm, 32'h1, {31'h0, ok});
    endtask
    task automatic wait_hi(input bit w, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while ((w ? done : pulse) !== 1'b1 && n < 5000);
    endtask
    task automatic run_chan(input logic [1:0] c, p, output logic [23:0] w);
        int n;
        @(posedge sys_clk);
        pat <= p;
        repeat (12) @(posedge sys_clk);
        // select moves only after the read
        {hi, lo} <= c;
        wait_hi(1'b0, n);
        chk("settle", n >= SETTLE_CLKS && n <= SETTLE_CLKS + 6);
        cmp("pair_sel", 32'h1 << c, {28'h0, pair});
        wait_hi(1'b0, n);
        cmp("word_gap", OSR * MOD_DIV, n);
        wait_hi(1'b1, n);
        w = word;
    endtask
    task automatic fill_drain();
        int n, k;
        @(posedge sys_clk);
        cmp_on <= 1'b0;
        stall <= 1'b1;
        repeat (20 * OSR * MOD_DIV) @(posedge sys_clk);
        stall <= 1'b0;
        k = 0;
        // Drained words come close together; arrivals are 384 apart
        for (n = 0; n < 200; n++) begin
            @(posedge sys_clk);
            #1;
            if (done) begin
                k++;
                n = 0;
            end
        end
        chk("fifo_keep", k >= FIFO_DEPTH + 1);
        chk("fifo_drop", k <= FIFO_DEPTH + 6);
    endtask
    task automatic print_verdict();
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        logic [23:0] wq, wa, ws, w0, wr;
        resetn = 1'b0;
        hi = 1'b0;
        lo = 1'b0;
        stall = 1'b0;
        pat = 2'h0;
        mcnt = 8'h0;
        mod_bit = 1'b0;
        pulse_d = 1'b0;
        cmp_on = 1'b1;
        err_total = 0;
        checks = 0;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        run_chan(2'h1, 2'h3, ws);
        run_chan(2'h2, 2'h2, wa);
        run_chan(2'h3, 2'h1, wq);
        run_chan(2'h0, 2'h0, w0);
        chk("average", $signed(w0) < $signed(wq) && $signed(wq) < $signed(wa));
        cmp("notch", {8'h0, wa}, {8'h0, ws});
        run_chan(2'h1, 2'h2, wr);
        cmp("restart", {8'h0, wa}, {8'h0, wr});
        fill_drain();
        print_verdict();
    end
    // Five settles, one long stall and the drain need about 21500 cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_total++;
        print_verdict();
    end
endmodule
